// ===== hw/i2cb_pkg.sv
`default_nettype none
package i2cb_pkg;
    // ****************************************
    // register indices (byte address is four times the index)
    // ****************************************
    localparam logic [7:0] IDX_CONFIG  = 8'hC8;
    localparam logic [7:0] IDX_STATUS  = 8'hC9;
    localparam logic [7:0] IDX_CONTROL = 8'hD8;
    localparam logic [7:0] IDX_DATA    = 8'hD9;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CFG_SLAVE_EN   = 7;
    localparam int CFG_MASTER_REQ = 6;
    localparam int CFG_CLR_TOVF   = 5;
    localparam int CFG_TIMER_RUN  = 4;
    localparam int CTL_CLR_TXA    = 7;
    localparam int CTL_IDLE       = 6;
    localparam int CTL_CLR_DATA_READY_FLAG   = 5;
    localparam int CTL_CLR_ARL    = 4;
    localparam int CTL_CLR_STR    = 3;
    localparam int CTL_CLR_STP    = 2;
    localparam int CTL_SEND_REPEAT_START_CMD       = 1;
    localparam int CTL_SEND_STOP_CMD       = 0;
    localparam int DATA_BIT       = 7;

    // ****************************************
    // timing
    // ****************************************
    localparam logic [2:0] MCYC_LAST = 3'h5;
    localparam logic [3:0] MIN_MET_COUNT = 4'h8;
    localparam logic [9:0] TMR_MAX = 10'h3FF;
    localparam logic [3:0] MT_SEL00 = 4'h5;
    localparam logic [3:0] MT_SEL01 = 4'h6;
    localparam logic [3:0] MT_SEL10 = 4'h7;
    localparam logic [3:0] MT_SEL11 = 4'h4;

    typedef enum logic [1:0] {MS_NONE, MS_START, MS_ACTIVE} i2cb_mst_t;

    typedef struct packed {
        logic       slave_enable;
        logic       master_request;
        logic       watch_timer_run;
        logic [1:0] min_time_select;
    } i2cb_cfg_t;

    typedef struct packed {
        logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
        logic [2:0] div;
        logic [9:0] tmr;
        i2cb_cfg_t  cfg;
        i2cb_mst_t  mst;
        logic       data_ready_flag, arb_loss_flag, start_seen_flag, stop_seen_flag;
        logic       tovf, rx_bit, tx_bit, tx_active, busy, slave_act;
        logic       rs_pend, sp_pend, sda_lvl, scl_drv, sda_drv, ack;
        logic [7:0] rdata;
    } i2cb_state_t;
endpackage
`default_nettype wire

// ===== hw/i2cb_port.sv
`default_nettype none
// Summary of operation
// RULE1: pending flags hold SCL low
// RULE2: clear-stop one clears stop flag
// RULE3: repeat start releases SDA, sets transmit
// RULE4: repeat start pulls SDA after min time
// RULE5: initial start generated on gaining mastership
// RULE6: software uses repeat start only as master
// RULE7: stop command pulls SDA low, sets transmit
// RULE8: stop releases SDA after min time
// RULE9: software clears master request before stop
// RULE10: data read gives bit7, clears flags; the code clears only the data ready flag (and transmit active)
// RULE11: data write loads bit, sets transmit
// RULE12: transmit bit reaches SDA only SCL low
// RULE13: software answers before watch timeout
// RULE14: slave enable, disable, timeout clears
// RULE15: master request, start, timeout clears
// RULE16: config bit5 clears overflow, reads zero
// RULE17: timer run bit, zero clears count
// RULE18: timing field sets min times
// RULE19: preload eight minus count on edges
// RULE20: timing field encodes count and timeout
// RULE21: run off only low bits count
// RULE22: data ready on SCL rise unless idle
// RULE23: timer steps once per six clocks
module i2cb_port
    import i2cb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);
    i2cb_state_t st;
    i2cb_state_t next_st;

    logic       scl_rise, scl_fall, start_det, stop_det, mcyc;
    logic       master, en, idle_slave, pend, min_met, req, acc;
    logic       wr_cfg, wr_ctl, wr_dat, rd_dat, timeout;
    logic [9:0] preload;

    function automatic logic [3:0] min_count(input logic [1:0] sel);
        logic [3:0] c;
        c = MT_SEL00;
        unique case (sel)
            2'h0: c = MT_SEL00;
            2'h1: c = MT_SEL01;
            2'h2: c = MT_SEL10;
            2'h3: c = MT_SEL11;
        endcase
        return c;
    endfunction

    // ****************************************
    // decode
    // ****************************************
    assign scl_rise   = st.scl_s & ~st.scl_p;
    assign scl_fall   = ~st.scl_s & st.scl_p;
    assign start_det  = st.scl_s & st.scl_p & st.sda_p & ~st.sda_s;
    assign stop_det   = st.scl_s & st.scl_p & ~st.sda_p & st.sda_s;
    assign mcyc       = (st.div == MCYC_LAST);
    assign master     = (st.mst != MS_NONE);
    assign en         = st.cfg.slave_enable | st.cfg.master_request | master; // [RULE14]
    assign idle_slave = ~master & ~st.slave_act;
    assign pend       = st.data_ready_flag | st.arb_loss_flag | st.start_seen_flag
                        | st.stop_seen_flag;
    assign min_met    = (st.tmr >= {6'h00, MIN_MET_COUNT});
    assign preload    = {6'h00, MIN_MET_COUNT - min_count(st.cfg.min_time_select)}; // [RULE19] [RULE20]
    assign req        = read | write;
    assign acc        = req & st.ack;
    assign wr_cfg     = acc & write & (address == IDX_CONFIG);
    assign wr_ctl     = acc & write & (address == IDX_CONTROL);
    assign wr_dat     = acc & write & (address == IDX_DATA);
    assign rd_dat     = acc & read & (address == IDX_DATA);
    // the timeout window comes from the preload (3, 2, 1 or 4 by min_time_select) counting up to 1023
    assign timeout    = en & st.cfg.watch_timer_run & (master | st.busy) & mcyc
                        & (st.tmr == TMR_MAX); // [RULE20]

    assign waitrequest = req & ~st.ack;
    assign readdata    = {24'h000000, st.rdata};
    assign scl_o       = 1'b0;
    assign sda_o       = 1'b0;
    assign scl_oe      = st.scl_drv;
    assign sda_oe      = st.sda_drv;

    always_comb begin
        next_st = st;
        // two-stage synchronisers; the second stage and a third, delayed stage feed logic
        next_st.scl_m = scl_i;
        next_st.scl_s = st.scl_m;
        next_st.scl_p = st.scl_s;
        next_st.sda_m = sda_i;
        next_st.sda_s = st.sda_m;
        next_st.sda_p = st.sda_s;
        next_st.div   = mcyc ? 3'h0 : st.div + 3'h1; // [RULE23]

        // ****************************************
        // bus slave: one wait cycle, then answer
        // ****************************************
        next_st.ack = req & ~st.ack;
        if (req & ~st.ack) begin
            case (address)
                IDX_CONFIG:  next_st.rdata = {st.cfg.slave_enable, st.cfg.master_request, 1'b0,
                                              st.cfg.watch_timer_run, 2'h0,
                                              st.cfg.min_time_select}; // [RULE16]
                IDX_STATUS:  next_st.rdata = {master, st.tovf, st.busy, st.tx_active, 4'h0};
                IDX_CONTROL: next_st.rdata = {st.rx_bit, pend, st.data_ready_flag,
                                              st.arb_loss_flag, st.start_seen_flag,
                                              st.stop_seen_flag, master, 1'b0};
                IDX_DATA:    next_st.rdata = {st.rx_bit, 7'h00}; // [RULE10]
                default:     next_st.rdata = 8'h00;
            endcase
        end
        if (wr_cfg) begin
            next_st.cfg.slave_enable    = writedata[CFG_SLAVE_EN]; // [RULE14]
            next_st.cfg.master_request  = writedata[CFG_MASTER_REQ]; // [RULE15]
            next_st.cfg.watch_timer_run = writedata[CFG_TIMER_RUN];
            next_st.cfg.min_time_select = writedata[1:0]; // [RULE18]
            if (writedata[CFG_CLR_TOVF]) begin
                next_st.tovf = 1'b0; // [RULE16]
            end
        end
        if (wr_ctl) begin
            if (writedata[CTL_CLR_TXA])  next_st.tx_active       = 1'b0;
            if (writedata[CTL_IDLE])     next_st.slave_act       = 1'b0;
            if (writedata[CTL_CLR_DATA_READY_FLAG]) next_st.data_ready_flag = 1'b0;
            if (writedata[CTL_CLR_ARL])  next_st.arb_loss_flag   = 1'b0;
            if (writedata[CTL_CLR_STR])  next_st.start_seen_flag = 1'b0;
            if (writedata[CTL_CLR_STP])  next_st.stop_seen_flag  = 1'b0; // [RULE2]
            if (writedata[CTL_SEND_REPEAT_START_CMD] & writedata[CTL_CLR_DATA_READY_FLAG]) begin
                next_st.tx_bit    = 1'b1; // [RULE3]
                next_st.tx_active = 1'b1;
                next_st.rs_pend   = 1'b1;
            end
            if (writedata[CTL_SEND_STOP_CMD] & writedata[CTL_CLR_DATA_READY_FLAG]) begin
                next_st.tx_bit    = 1'b0; // [RULE7]
                next_st.tx_active = 1'b1;
                next_st.sp_pend   = 1'b1;
            end
        end
        if (wr_dat) begin
            next_st.tx_bit          = writedata[DATA_BIT]; // [RULE11]
            next_st.data_ready_flag = 1'b0;
            next_st.tx_active       = 1'b1;
        end
        if (rd_dat) begin
            next_st.data_ready_flag = 1'b0; // [RULE10]
            next_st.tx_active       = 1'b0;
        end
        // a bit written early, while SCL is still high, waits for the low phase
        if (~st.scl_s) begin
            next_st.sda_lvl = next_st.tx_bit; // [RULE12]
        end

        // ****************************************
        // watch timer
        // ****************************************
        if (~st.cfg.watch_timer_run & ~en) begin
            next_st.tmr = 10'h000;
        end else if (mcyc & ((st.cfg.watch_timer_run & (master | st.busy)) | ~min_met)) begin
            next_st.tmr = st.tmr + 10'h001; // [RULE21] [RULE23]
        end
        if (en & (scl_rise | scl_fall | start_det | stop_det)) begin
            next_st.tmr = preload; // [RULE19]
        end
        if (wr_cfg & ~writedata[CFG_TIMER_RUN]) begin
            next_st.tmr = 10'h000; // [RULE17]
        end

        // ****************************************
        // bit level events; hardware sets win over software clears
        // ****************************************
        if (scl_rise) begin
            next_st.rx_bit = st.sda_s;
        end
        if (en & scl_rise) begin
            if (~idle_slave) begin
                next_st.data_ready_flag = 1'b1; // [RULE22]
            end
            if (st.tx_active & st.sda_lvl & ~st.sda_s) begin
                next_st.arb_loss_flag = 1'b1;
                next_st.tx_active     = 1'b0;
                next_st.mst           = MS_NONE;
                next_st.rs_pend       = 1'b0;
                next_st.sp_pend       = 1'b0;
            end
        end
        if (master & st.scl_s & ~scl_rise & min_met) begin
            // fresh min time: no SCL drop right after a generated start or stop
            if (st.rs_pend | st.sp_pend) next_st.tmr = preload; // [RULE18]
            if (st.rs_pend) begin
                next_st.sda_lvl = 1'b0; // [RULE4]
                next_st.tx_bit  = 1'b0;
                next_st.rs_pend = 1'b0;
            end
            if (st.sp_pend) begin
                next_st.sda_lvl = 1'b1; // [RULE8]
                next_st.tx_bit  = 1'b1;
                next_st.sp_pend = 1'b0;
            end
        end
        if (start_det) begin
            next_st.busy = 1'b1;
        end
        if (en & start_det) begin
            if ((st.mst == MS_ACTIVE) | st.slave_act) begin
                next_st.start_seen_flag = 1'b1;
            end
            if (st.mst == MS_START) begin
                next_st.mst             = MS_ACTIVE;
                next_st.data_ready_flag = 1'b1; // [RULE15]
            end else if (~master & st.cfg.slave_enable) begin
                next_st.slave_act = 1'b1;
            end
        end
        if (stop_det) begin
            next_st.busy = 1'b0;
        end
        if (en & stop_det) begin
            if (master | st.slave_act) begin
                next_st.stop_seen_flag = 1'b1;
            end
            next_st.slave_act = 1'b0;
            next_st.mst       = MS_NONE;
            next_st.tx_active = 1'b0;
        end

        // ****************************************
        // mastership and the initial start
        // ****************************************
        if (st.cfg.master_request & ~master & ~st.busy & st.scl_s & st.sda_s) begin
            next_st.mst = MS_START; // [RULE15]
            next_st.tmr = preload;
        end
        if ((st.mst == MS_START) & min_met) begin
            next_st.sda_lvl   = 1'b0; // [RULE5]
            next_st.tx_bit    = 1'b0;
            next_st.tx_active = 1'b1;
        end

        // ****************************************
        // SCL drive: master clocking and stretching
        // ****************************************
        if (~en) begin
            next_st.scl_drv = 1'b0;
        end else if (scl_fall & ~idle_slave) begin
            next_st.scl_drv = 1'b1; // [RULE1]
        end else if ((st.mst == MS_ACTIVE) & st.scl_s & ~scl_rise & min_met
                     & ~st.rs_pend & ~st.sp_pend) begin
            next_st.scl_drv = 1'b1; // [RULE18]
        end else if (st.scl_drv & ~st.scl_s & ~scl_fall & ~pend & (min_met | ~master)) begin
            next_st.scl_drv = 1'b0; // [RULE1]
        end

        // a hung bus drops enables, mastership, busy and line drives back to idle; the status flags are kept
        if (timeout) begin
            next_st.tovf               = 1'b1;
            next_st.cfg.slave_enable   = 1'b0; // [RULE14]
            next_st.cfg.master_request = 1'b0; // [RULE15]
            next_st.mst                = MS_NONE;
            next_st.busy               = 1'b0;
            next_st.slave_act          = 1'b0;
            next_st.scl_drv            = 1'b0;
            next_st.tx_active          = 1'b0;
            next_st.rs_pend            = 1'b0;
            next_st.sp_pend            = 1'b0;
            next_st.tmr                = 10'h000;
        end
        next_st.sda_drv = en & next_st.tx_active & ~next_st.sda_lvl;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.scl_m   <= 1'b1;
            st.scl_s   <= 1'b1;
            st.scl_p   <= 1'b1;
            st.sda_m   <= 1'b1;
            st.sda_s   <= 1'b1;
            st.sda_p   <= 1'b1;
            st.sda_lvl <= 1'b1;
            st.tx_bit  <= 1'b1;
            st.mst     <= MS_NONE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_scl_stretch_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
        (st.scl_drv && !st.scl_s && pend && en) |=> (st.scl_drv || st.tovf))
        else $error("scl released while flags pending");
    a_clear_stop_bit: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
        (wr_ctl && writedata[CTL_CLR_STP] && !stop_det) |=> !st.stop_seen_flag)
        else $error("stop flag not cleared");
    a_repeat_start_cmd: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
        (wr_ctl && writedata[CTL_SEND_REPEAT_START_CMD] && writedata[CTL_CLR_DATA_READY_FLAG] && !writedata[CTL_SEND_STOP_CMD]
         && !timeout) |=> (st.tx_active && st.tx_bit && st.rs_pend))
        else $error("repeat start not armed");
    a_stop_cmd_arm: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
        (wr_ctl && writedata[CTL_SEND_STOP_CMD] && writedata[CTL_CLR_DATA_READY_FLAG] && !writedata[CTL_SEND_REPEAT_START_CMD]
         && !timeout) |=> (st.tx_active && !st.tx_bit && st.sp_pend))
        else $error("stop not armed");
    a_data_read_clear: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
        (rd_dat && !(en && scl_rise) && !(en && start_det))
        |-> (readdata == {24'h000000, $past(st.rx_bit), 7'h00}) ##1 !st.data_ready_flag)
        else $error("data read wrong");
    a_sda_high_change: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
        ($changed(st.sda_lvl) && $past(st.scl_s) && $past(st.mst) != MS_NONE)
        |-> ($past(st.rs_pend) || $past(st.sp_pend) || $past(st.mst) == MS_START))
        else $error("sda moved while scl high");
    a_ready_on_rise: assert property (@(posedge clock) disable iff (!rst_n) // [RULE22]
        (en && scl_rise && !idle_slave) |=> st.data_ready_flag)
        else $error("data ready not set");
    a_timer_preload: assert property (@(posedge clock) disable iff (!rst_n) // [RULE19]
        (en && scl_fall && !wr_cfg && !timeout) |=> (st.tmr == $past(preload)))
        else $error("timer preload wrong");
    a_timeout_clears: assert property (@(posedge clock) disable iff (!rst_n) // [RULE14]
        timeout |=> (!st.cfg.slave_enable && !st.cfg.master_request && st.tovf
                     && st.mst == MS_NONE))
        else $error("timeout did not clear enables");
    a_timer_step: assert property (@(posedge clock) disable iff (!rst_n) // [RULE23]
        (st.tmr != $past(st.tmr) && !$past(scl_rise) && !$past(scl_fall)
         && !$past(start_det) && !$past(stop_det) && st.tmr != 10'h000
         && $past(st.mst) == st.mst && $past(st.rs_pend) == st.rs_pend
         && $past(st.sp_pend) == st.sp_pend) |-> $past(mcyc))
        else $error("timer stepped off machine cycle");
endmodule
`default_nettype wire

// ===== tb/i2cb_peer.sv
`default_nettype none
// ****************************************
// far-side bus device, open-drain pulls
// ****************************************
module i2cb_peer (
    input  wire logic scl,
    input  wire logic sda,
    output var  logic scl_pull,
    output var  logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    task automatic start_c;
        sda_pull = 1'b1;
        #400;
        scl_pull = 1'b1;
        #200;
    endtask

    // data changes only while the clock is low; a one releases the line
    task automatic bit_c(input logic b);
        sda_pull = !b;
        #200;
        scl_pull = 1'b0;
        wait (scl === 1'b1);
        #410;
        scl_pull = 1'b1;
        #200;
    endtask

    task automatic stop_c;
        sda_pull = 1'b1;
        #200;
        scl_pull = 1'b0;
        wait (scl === 1'b1);
        #410;
        sda_pull = 1'b0;
        #400;
    endtask
endmodule
`default_nettype wire

// ===== tb/i2c_bit_level_port_tb_top.sv
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR at %0t got %h exp %h", $time, (g), (e)); end end
module i2c_bit_level_port_tb_top
    import i2cb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock, rst_n, read, write, waitrequest;
    logic [7:0]  address, v;
    logic [31:0] writedata, readdata;
    logic        scl_oe, sda_oe, p_scl, p_sda, scl_w, sda_w, mon_en, sda_q, p_done;
    logic        scl_lo, sda_lo;
    int          fail_count, n_compared, cycles, n;
    int          mt_tab [4] = '{5, 6, 7, 4};

    assign scl_w = !(scl_oe | p_scl);
    assign sda_w = !(sda_oe | p_sda);

    i2cb_port DUT (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .scl_i(scl_w), .scl_o(scl_lo), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(sda_lo), .sda_oe(sda_oe));
    i2cb_peer peer (.scl(scl_w), .sda(sda_w), .scl_pull(p_scl), .sda_pull(p_sda));

    always #50 clock = ~clock;

    // ****************************************
    // bus access and checks
    // ****************************************
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writedata <= {24'h000000, d};
        write <= 1'b1;
        @(posedge clock iff waitrequest === 1'b0);
        write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        address <= a;
        read <= 1'b1;
        @(posedge clock iff waitrequest === 1'b0);
        d = readdata[7:0];
        read <= 1'b0;
    endtask

    task automatic poll_ready;
        do reg_rd(IDX_CONTROL, v); while (v[5] !== 1'b1);
    endtask

    task automatic chk_range(input int got, input int lo, input int hi);
        `CHK(got >= lo && got <= hi, 1'b1)
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // sda may only be pulled while the wire clock is low
    always @(posedge clock) begin
        sda_q <= sda_oe;
        if (mon_en && sda_oe === 1'b1 && sda_q === 1'b0) `CHK(scl_w, 1'b0)
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h00000000;
        mon_en = 1'b0;
        p_done = 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        reg_rd(IDX_CONFIG, v);
        `CHK(v, CONFIG_RESET)
        reg_rd(8'h10, v);
        `CHK(v, 8'h00)
        reg_wr(IDX_CONFIG, 8'hB3);
        reg_rd(IDX_CONFIG, v);
        `CHK(v, 8'h93)
        $display("test registers done");

        reg_wr(IDX_CONFIG, 8'h83);
        mon_en = 1'b1;
        fork
            begin
                #20;
                peer.start_c();
                peer.bit_c(1'b1);
                peer.bit_c(1'b0);
                peer.bit_c(1'b1);
                peer.stop_c();
                p_done = 1'b1;
            end
        join_none
        poll_ready();
        `CHK(v, 8'hE0)
        @(posedge clock iff scl_oe === 1'b1);
        repeat (20) @(posedge clock);
        `CHK(scl_oe, 1'b1)
        `CHK({scl_lo, sda_lo}, 2'b00)
        reg_rd(IDX_DATA, v);
        `CHK(v, 8'h80)
        poll_ready();
        `CHK(v, 8'h60)
        reg_wr(IDX_DATA, 8'h00);
        poll_ready();
        `CHK(v, 8'h60)
        reg_rd(IDX_DATA, v);
        `CHK(v, 8'h00)
        @(posedge clock iff p_done === 1'b1);
        repeat (10) @(posedge clock);
        reg_rd(IDX_CONTROL, v);
        `CHK(v, 8'h64)
        reg_wr(IDX_CONTROL, 8'h00);
        reg_rd(IDX_CONTROL, v);
        `CHK(v, 8'h64)
        reg_wr(IDX_CONTROL, 8'h24);
        reg_rd(IDX_CONTROL, v);
        `CHK(v, 8'h00)
        mon_en = 1'b0;
        $display("test slave done");

        // windows allow for input synchronisers and machine-cycle phase
        for (int s = 0; s < 4; s++) begin
            reg_wr(IDX_CONFIG, 8'h40 | 8'(s));
            @(posedge clock iff sda_oe === 1'b1);
            `CHK(scl_w, 1'b1)
            n = 0;
            while (scl_oe !== 1'b1) begin
                @(posedge clock);
                n++;
            end
            chk_range(n, mt_tab[s] * 6 - 6, mt_tab[s] * 6 + 9);
            reg_rd(IDX_CONTROL, v);
            `CHK(v & 8'h7F, 8'h62)
            reg_wr(IDX_CONTROL, 8'h2A);
            @(posedge clock iff scl_w === 1'b1);
            `CHK(sda_oe, 1'b0)
            n = 0;
            while (sda_oe !== 1'b1) begin
                @(posedge clock);
                n++;
            end
            chk_range(n, mt_tab[s] * 6 - 6, mt_tab[s] * 6 + 9);
            `CHK(scl_w, 1'b1)
            @(posedge clock iff scl_oe === 1'b1);
            reg_wr(IDX_CONFIG, 8'(s));
            reg_wr(IDX_CONTROL, 8'h29);
            @(posedge clock iff scl_w === 1'b1);
            `CHK(sda_oe, 1'b1)
            n = 0;
            while (sda_oe !== 1'b0) begin
                @(posedge clock);
                n++;
            end
            chk_range(n, mt_tab[s] * 6 - 6, mt_tab[s] * 6 + 9);
            repeat (10) @(posedge clock);
            reg_rd(IDX_CONTROL, v);
            `CHK(v & 8'h7F, 8'h64)
            reg_wr(IDX_CONTROL, 8'h3C);
            $display("test master select %0d done", s);
        end

        reg_wr(IDX_CONFIG, 8'hC3);
        repeat (7000) @(posedge clock);
        reg_rd(IDX_CONFIG, v);
        `CHK(v, 8'hC3)
        reg_wr(IDX_CONFIG, 8'hD3);
        repeat (7000) @(posedge clock);
        reg_rd(IDX_CONFIG, v);
        `CHK(v, 8'h13)
        reg_rd(IDX_STATUS, v);
        `CHK(v, 8'h40)
        reg_wr(IDX_CONFIG, 8'h20);
        reg_rd(IDX_CONFIG, v);
        `CHK(v, 8'h00)
        reg_rd(IDX_STATUS, v);
        `CHK(v, 8'h00)
        $display("test timeout done");
        conclude();
    end
endmodule
`default_nettype wire
